// File: vsu_top.sv
/*
 vsu_top: vector shift pipeline. takes one shift per issue, latches
 count and length, streams source elements in, results out, and
 reports when the source, destination and unit are released.
 assumes issue control honours the free conditions before issuing
 and streams source elements one per clock while SRC_READY is high.
*/
// Summary of operation
// - single right shift moves each element right with zero fill.
// - the count is unsigned 32 bits and single counts of 64 or more give zero.
// - double left joins element with the next and keeps the upper 64.
// - double left puts zeros below the last element.
// - double shift counts of 128 or more give zero.
// - double left fills zeros at the low end.
// - double right starts with the first element below a cleared top.
// - later double right pairs put the previous element on top.
// - double right fills zeros at the high end.
// - count is held from issue and length elements are processed, one element for a length of zero.
// - right shifts free the destination at phase 27 plus 2 per element past the first.
// - double left frees the destination at phase 20 plus 2 per element past the first.
// - source frees at 17 and unit at 20, plus 2 per element past 4.
`timescale 1ns/1ns
module vsu_top
	import vsu_pkg::*;
(
	input  wire logic              MCLK,
	input  wire logic              SYS_RST,
	input  wire logic              ISSUE,
	input  vsu_issue_t             ISSUE_CMD,
	input  vsu_elem_t              SRC_ELEM,
	output logic                   SRC_READY,
	output vsu_elem_t              DST_ELEM,
	output logic                   BUSY,
	output logic                   SRC_FREE,
	output logic                   DST_FREE,
	output logic                   UNIT_FREE
);
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN,
		ST_DRAIN
	} vsu_state_t;

	localparam int TW = 10;

	vsu_state_t          state_r, state_nxt;
	vsu_op_t             op_r, op_nxt;
	logic [CNT_W-1:0]    count_r, count_nxt;
	logic [VL_W-1:0]     len_r, len_nxt;
	logic [VL_W-1:0]     taken_r, taken_nxt;
	logic [ELEM_W-1:0]   prev_r, prev_nxt;
	logic                have_prev_r, have_prev_nxt;
	logic                out_v_r, out_v_nxt;
	logic [TW-1:0]       tick_r, tick_nxt;
	logic [TW-1:0]       src_at_r, src_at_nxt;
	logic [TW-1:0]       dst_at_r, dst_at_nxt;
	logic [TW-1:0]       unit_at_r, unit_at_nxt;
	logic                load;
	logic [2*ELEM_W-1:0] field;
	logic [ELEM_W-1:0]   result;

	// cycles past the base for an element count beyond a threshold
	function automatic logic [TW-1:0] extra(input logic [VL_W-1:0] n,
		input logic [VL_W-1:0] base);
		extra = (n > base) ? TW'(n - base) : '0;
	endfunction

	logic [VL_W-1:0] eff_len;
	assign eff_len = (ISSUE_CMD.length == '0) ? VL_W'(1) : ISSUE_CMD.length;

	always_comb begin
		state_nxt     = state_r;
		op_nxt        = op_r;
		count_nxt     = count_r;
		len_nxt       = len_r;
		taken_nxt     = taken_r;
		prev_nxt      = prev_r;
		have_prev_nxt = have_prev_r;
		out_v_nxt     = 1'b0;
		tick_nxt      = (tick_r == '1) ? tick_r : tick_r + TW'(1);
		src_at_nxt    = src_at_r;
		dst_at_nxt    = dst_at_r;
		unit_at_nxt   = unit_at_r;
		load          = 1'b0;
		field         = '0;
		unique case (state_r)
			ST_IDLE: begin
				if (ISSUE && ISSUE_CMD.op != VSU_OP_NONE) begin
					state_nxt     = ST_RUN;
					op_nxt        = ISSUE_CMD.op;
					count_nxt     = ISSUE_CMD.count;
					len_nxt       = eff_len;
					taken_nxt     = '0;
					have_prev_nxt = 1'b0;
					prev_nxt      = '0;
					tick_nxt      = '0;
					src_at_nxt    = TW'(CYC_SRC_FREE)
						+ extra(eff_len, VL_W'(BASE_ELEMS));
					unit_at_nxt   = TW'(CYC_UNIT_FREE)
						+ extra(eff_len, VL_W'(BASE_ELEMS));
					dst_at_nxt    = ((ISSUE_CMD.op == VSU_OP_DSHL)
						? TW'(CYC_DEST_LEFT)
						: TW'(CYC_DEST_RIGHT))
						+ extra(eff_len, VL_W'(1));
				end
			end
			ST_RUN: begin
				if (SRC_ELEM.valid) begin
					taken_nxt     = taken_r + VL_W'(1);
					prev_nxt      = SRC_ELEM.data;
					have_prev_nxt = 1'b1;
					unique case (op_r)
						VSU_OP_SHR: begin
							load  = 1'b1;
							field = {{ELEM_W{1'b0}}, SRC_ELEM.data};
						end
						VSU_OP_DSHR: begin
							load  = 1'b1;
							// first element sits under a cleared upper half
							field = {have_prev_r ? prev_r : {ELEM_W{1'b0}},
								SRC_ELEM.data};
						end
						default: begin
							// left pair needs the next element before output
							load  = have_prev_r;
							field = {prev_r, SRC_ELEM.data};
						end
					endcase
					out_v_nxt = load;
					if (taken_r + VL_W'(1) == len_r)
						state_nxt = (op_r == VSU_OP_DSHL) ? ST_DRAIN : ST_IDLE;
				end
			end
			ST_DRAIN: begin
				// last element on top, zeros below
				load      = 1'b1;
				field     = {prev_r, {ELEM_W{1'b0}}};
				out_v_nxt = 1'b1;
				state_nxt = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state_r     <= ST_IDLE;
			op_r        <= VSU_OP_NONE;
			count_r     <= '0;
			len_r       <= '0;
			taken_r     <= '0;
			prev_r      <= '0;
			have_prev_r <= 1'b0;
			out_v_r     <= 1'b0;
			tick_r      <= '1;
			src_at_r    <= '0;
			dst_at_r    <= '0;
			unit_at_r   <= '0;
		end else begin
			state_r     <= state_nxt;
			op_r        <= op_nxt;
			count_r     <= count_nxt;
			len_r       <= len_nxt;
			taken_r     <= taken_nxt;
			prev_r      <= prev_nxt;
			have_prev_r <= have_prev_nxt;
			out_v_r     <= out_v_nxt;
			tick_r      <= tick_nxt;
			src_at_r    <= src_at_nxt;
			dst_at_r    <= dst_at_nxt;
			unit_at_r   <= unit_at_nxt;
		end
	end

	vsu_shifter u_shift (
		.MCLK   (MCLK),
		.SYS_RST(SYS_RST),
		.LOAD   (load),
		.MODE   (op_r),
		.FIELD  (field),
		.COUNT  (count_r),
		.RESULT (result)
	);

	// issue accepts on the same edge, so the next instruction is not held
	assign SRC_READY      = (state_r == ST_RUN);
	assign BUSY           = (state_r != ST_IDLE);
	assign DST_ELEM.valid = out_v_r;
	assign DST_ELEM.data  = result;
	// tick counts clocks since issue; source and destination releases are absolute, unit release also waits for BUSY low
	assign SRC_FREE  = (tick_r >= src_at_r);
	assign UNIT_FREE = (tick_r >= unit_at_r) && !BUSY;
	assign DST_FREE  = (tick_r >= dst_at_r);

	// plain expression, so it may be combined with && in the antecedents
	logic issue_hit;
	assign issue_hit = (state_r == ST_IDLE) && ISSUE
		&& (ISSUE_CMD.op != VSU_OP_NONE);

	count_held_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
		state_r != ST_IDLE && state_nxt != ST_IDLE
		|=> $stable(count_r))
		else $error("count changed mid stream");
	src_release_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
		issue_hit && ISSUE_CMD.length <= VL_W'(BASE_ELEMS)
		&& ISSUE_CMD.length != '0
		|=> !SRC_FREE [*8] ##1 !SRC_FREE ##1 SRC_FREE)
		else $error("source release not at phase 17");
	dst_right_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
		issue_hit && ISSUE_CMD.op != VSU_OP_DSHL && ISSUE_CMD.length == 1
		|=> ##13 !DST_FREE ##1 DST_FREE)
		else $error("right destination release not at phase 27");
	dst_left_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
		issue_hit && ISSUE_CMD.op == VSU_OP_DSHL && ISSUE_CMD.length == 1
		|=> ##9 !DST_FREE ##1 DST_FREE)
		else $error("left destination release not at phase 20");
	drain_zero_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
		state_r == ST_DRAIN |-> load && field[ELEM_W-1:0] == '0)
		else $error("last left pair lower half not zero");
	right_first_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
		state_r == ST_RUN && op_r == VSU_OP_DSHR && SRC_ELEM.valid
		&& !have_prev_r |-> field[2*ELEM_W-1:ELEM_W] == '0)
		else $error("first right pair upper half not clear");
	right_later_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
		state_r == ST_RUN && op_r == VSU_OP_DSHR && SRC_ELEM.valid
		&& have_prev_r |-> field[2*ELEM_W-1:ELEM_W] == prev_r)
		else $error("later right pair upper half wrong");
	elem_count_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
		state_r == ST_RUN && state_nxt == ST_IDLE
		|-> taken_r + VL_W'(1) == len_r)
		else $error("stream ended at wrong length");
endmodule

// File: vsu_pkg.sv
/*
 vector shift unit package: operation codes, element and count widths,
 release timing in half-clock phases, and the stream carrier structs.
 assumes one clock of two phases; phase counts map to clock cycles.
*/
package vsu_pkg;

	localparam int ELEM_W       = 64;
	localparam int CNT_W        = 32;
	localparam int VL_W         = 7;
	localparam int PHASES_PER_CLK = 2;

	// release times in phases after issue
	localparam int PH_DEST_RIGHT = 27;
	localparam int PH_DEST_LEFT  = 20;
	localparam int PH_SRC_FREE   = 17;
	localparam int PH_UNIT_FREE  = 20;
	localparam int BASE_ELEMS    = 4;

	// converted to whole clock cycles (least times round up)
	localparam int CYC_DEST_RIGHT =
		(PH_DEST_RIGHT + PHASES_PER_CLK - 1) / PHASES_PER_CLK;
	localparam int CYC_DEST_LEFT  =
		(PH_DEST_LEFT + PHASES_PER_CLK - 1) / PHASES_PER_CLK;
	localparam int CYC_SRC_FREE   =
		(PH_SRC_FREE + PHASES_PER_CLK - 1) / PHASES_PER_CLK;
	localparam int CYC_UNIT_FREE  =
		(PH_UNIT_FREE + PHASES_PER_CLK - 1) / PHASES_PER_CLK;

	localparam logic [CNT_W-1:0] SINGLE_LIMIT = 32'h0000_0040;
	localparam logic [CNT_W-1:0] DOUBLE_LIMIT = 32'h0000_0080;

	typedef enum logic [1:0] {
		VSU_OP_SHR    = 2'h0,
		VSU_OP_DSHL   = 2'h1,
		VSU_OP_DSHR   = 2'h2,
		VSU_OP_NONE   = 2'h3
	} vsu_op_t;

	typedef struct packed {
		vsu_op_t           op;
		logic [CNT_W-1:0]  count;
		logic [VL_W-1:0]   length;
	} vsu_issue_t;

	typedef struct packed {
		logic              valid;
		logic [ELEM_W-1:0] data;
	} vsu_elem_t;

endpackage

// File: vsu_shifter.sv
/*
 vsu_shifter: combinational 128-bit funnel with a registered result.
 assumes the caller presents the pair already placed in the field.
*/
`timescale 1ns/1ns
module vsu_shifter
	import vsu_pkg::*;
(
	input  wire logic                MCLK,
	input  wire logic                SYS_RST,
	input  wire logic                LOAD,
	input  wire logic [1:0]          MODE,
	input  wire logic [2*ELEM_W-1:0] FIELD,
	input  wire logic [CNT_W-1:0]    COUNT,
	output logic      [ELEM_W-1:0]   RESULT
);
	logic [ELEM_W-1:0]   result_r;
	logic [ELEM_W-1:0]   result_nxt;
	logic [2*ELEM_W-1:0] wide;

	always_comb begin
		wide       = '0;
		result_nxt = result_r;
		if (LOAD) begin
			unique case (MODE)
				2'h0: begin
					// single: zero fill from top
					if (COUNT >= SINGLE_LIMIT)
						result_nxt = '0;
					else
						result_nxt = FIELD[ELEM_W-1:0] >> COUNT[5:0];
				end
				2'h1: begin
					// zeros enter at the low end
					wide = FIELD << COUNT[6:0];
					if (COUNT >= DOUBLE_LIMIT)
						result_nxt = '0;
					else
						result_nxt = wide[2*ELEM_W-1:ELEM_W];
				end
				default: begin
					// zeros enter at the high end
					wide = FIELD >> COUNT[6:0];
					if (COUNT >= DOUBLE_LIMIT)
						result_nxt = '0;
					else
						result_nxt = wide[ELEM_W-1:0];
				end
			endcase
		end
	end

	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST)
			result_r <= '0;
		else
			result_r <= result_nxt;
	end

	assign RESULT = result_r;

	single_zero_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
		LOAD && MODE == 2'h0 && COUNT >= SINGLE_LIMIT |=> RESULT == '0)
		else $error("single shift over limit not zero");
	double_zero_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
		LOAD && MODE != 2'h0 && COUNT >= DOUBLE_LIMIT |=> RESULT == '0)
		else $error("double shift over limit not zero");
	left_pick_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
		LOAD && MODE == 2'h1 && COUNT == '0
		|=> RESULT == $past(FIELD[2*ELEM_W-1:ELEM_W]))
		else $error("left pair zero count not upper half");
endmodule

// File: vsu_src_model.sv
/*
 vsu_src_model: source vector register and destination sink for the
 shift unit. assumes START pulses on the edge at which an issue is taken.
*/
`timescale 1ns/1ns
module vsu_src_model
	import vsu_pkg::*;
(
	input  wire logic            MCLK,
	input  wire logic            SYS_RST,
	input  wire logic            START,
	input  wire logic            SLOW,
	input  wire logic [VL_W-1:0] LEN,
	input  wire logic            SRC_READY,
	input  vsu_elem_t            DST_ELEM,
	output vsu_elem_t            SRC_ELEM,
	output logic      [VL_W-1:0] RCNT
);
	logic [ELEM_W-1:0] res [0:127];
	logic [VL_W-1:0]   idx;
	logic              gap;
	logic              act;
	logic [ELEM_W-1:0] word;
	assign word = 64'h8421_F0E1_D2C3_B4A5 ^ {8{1'b0, idx}};
	assign act = (idx < LEN) && !gap;
	// idle lines carry the inverse word so stale data never looks valid
	assign SRC_ELEM = {act, act ? word : ~word};
	always @(posedge MCLK) begin
		if (SYS_RST || START) begin
			idx <= '0;
			gap <= 1'b0;
			RCNT <= '0;
		end else begin
			// an offered element is held until it is taken
			if (gap)
				gap <= 1'b0;
			else if (act && SRC_READY) begin
				idx <= idx + 1'b1;
				gap <= SLOW;
			end
			if (DST_ELEM.valid) begin
				res[RCNT] <= DST_ELEM.data;
				RCNT <= RCNT + 1'b1;
			end
		end
	end
endmodule

// File: testbench.sv
/*
 testbench: drives issues into vsu_top, streams a source vector through
 the partner model and checks results and release times.
 assumes a free running 100 MHz clock and no other masters.
*/
`timescale 1ns/1ns
module testbench;
	import vsu_pkg::*;
	logic            MCLK;
	logic            SYS_RST;
	logic            ISSUE;
	vsu_issue_t      ISSUE_CMD;
	vsu_elem_t       SRC_ELEM;
	vsu_elem_t       DST_ELEM;
	logic            SRC_READY;
	logic            BUSY;
	logic            SRC_FREE;
	logic            DST_FREE;
	logic            UNIT_FREE;
	logic            SLOW;
	logic [VL_W-1:0] RCNT;
	int              err_count;
	int              tests_run;
	int              base;
	localparam logic [63:0] ZERO = 64'h0000_0000_0000_0000;
	localparam logic [31:0] CNTS [6] = '{32'h0000_0000, 32'h0000_0005,
		32'h0000_0040, 32'h0000_0041, 32'h0000_0080, 32'hFFFF_FFFF};

	vsu_top vsu_top_inst (.MCLK(MCLK), .SYS_RST(SYS_RST), .ISSUE(ISSUE),
		.ISSUE_CMD(ISSUE_CMD), .SRC_ELEM(SRC_ELEM), .SRC_READY(SRC_READY),
		.DST_ELEM(DST_ELEM), .BUSY(BUSY), .SRC_FREE(SRC_FREE),
		.DST_FREE(DST_FREE), .UNIT_FREE(UNIT_FREE));
	vsu_src_model vsu_src_model_inst (.MCLK(MCLK), .SYS_RST(SYS_RST),
		.START(ISSUE && !BUSY), .SLOW(SLOW), .LEN(ISSUE_CMD.length),
		.SRC_READY(SRC_READY), .DST_ELEM(DST_ELEM), .SRC_ELEM(SRC_ELEM),
		.RCNT(RCNT));

	initial begin
		MCLK = 1'b0;
		forever #5 MCLK = ~MCLK;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
			err_count++;
		end
	endtask

	task automatic timeout();
		err_count++;
		report_and_stop();
	endtask

	function automatic logic [63:0] elem(int i);
		return 64'h8421_F0E1_D2C3_B4A5 ^ {8{i[7:0]}};
	endfunction

	// shifts past the field width come out zero in the language itself
	function automatic logic [63:0] expv(vsu_op_t op, logic [31:0] c,
		int i, int l);
		logic [127:0] f;
		if (op == VSU_OP_DSHL)
			f = {elem(i), (i + 1 < l) ? elem(i + 1) : ZERO} << c;
		else
			f = {(i > 0) ? elem(i - 1) : ZERO, elem(i)} >> c;
		return (op == VSU_OP_SHR) ? elem(i) >> c :
			(op == VSU_OP_DSHL) ? f[127:64] : f[63:0];
	endfunction

	task automatic run_op(vsu_op_t op, logic [31:0] c, int l,
		logic slow, logic again);
		int n;
		int ts;
		int tu;
		int td;
		ts = 0;
		tu = 0;
		td = 0;
		n = 0;
		while (UNIT_FREE !== 1'b1) begin
			@(posedge MCLK);
			n++;
			if (n > 50)
				timeout();
		end
		@(posedge MCLK);
		SLOW <= slow;
		ISSUE <= 1'b1;
		ISSUE_CMD <= '{op: op, count: c, length: l[VL_W-1:0]};
		@(posedge MCLK);
		// a repeat issue while busy must be ignored
		ISSUE <= again;
		ISSUE_CMD.count <= ~c;
		#1 chk("busy", BUSY, 1);
		@(posedge MCLK);
		ISSUE <= 1'b0;
		for (n = 2; !(ts && tu && td && RCNT == l && !BUSY); n++) begin
			if (n > 300)
				timeout();
			#1;
			if (ts == 0 && SRC_FREE === 1'b1)
				ts = n;
			if (tu == 0 && UNIT_FREE === 1'b1)
				tu = n;
			if (td == 0 && DST_FREE === 1'b1)
				td = n;
			@(posedge MCLK);
		end
		for (int i = 0; i < l; i++)
			chk("result", vsu_src_model_inst.res[i], expv(op, c, i, l));
		chk("count", RCNT, l);
		if (!slow) begin
			if (l == 1 && op == VSU_OP_SHR)
				base = ts;
			chk("src free", ts, base + ((l > 4) ? l - 4 : 0));
			chk("unit free", tu - ts, 1);
			chk("dst free", td - ts, ((op == VSU_OP_DSHL) ? 1 : 5) + l - 1
				- ((l > 4) ? l - 4 : 0));
		end
	endtask

	task automatic t_timing();
		run_op(VSU_OP_SHR, 32'h0000_0003, 1, 1'b0, 1'b0);
		for (int o = 0; o < 3; o++) begin
			run_op(vsu_op_t'(o), 32'h0000_0003, 1, 1'b0, 1'b0);
			run_op(vsu_op_t'(o), 32'h0000_0003, 6, 1'b0, 1'b0);
		end
		$display("test timing done");
	endtask

	task automatic t_single();
		foreach (CNTS[k])
			run_op(VSU_OP_SHR, CNTS[k] >> (k == 4), 3, 1'b0, k == 1);
		$display("test single done");
	endtask

	task automatic t_double();
		foreach (CNTS[k]) begin
			run_op(VSU_OP_DSHL, CNTS[k] << (k == 3), 4, 1'b0, k == 2);
			run_op(VSU_OP_DSHR, CNTS[k] << (k == 3), 4, 1'b0, 1'b0);
		end
		$display("test double done");
	endtask

	task automatic t_stream();
		run_op(VSU_OP_DSHL, 32'h0000_0021, 5, 1'b1, 1'b0);
		run_op(VSU_OP_DSHR, 32'h0000_004F, 5, 1'b1, 1'b0);
		$display("test stream done");
	endtask

	task automatic t_refuse();
		@(posedge MCLK);
		ISSUE <= 1'b1;
		ISSUE_CMD.op <= VSU_OP_NONE;
		@(posedge MCLK);
		ISSUE <= 1'b0;
		#1 chk("idle busy", BUSY, 0);
		chk("idle unit", UNIT_FREE, 1);
		$display("test refuse done");
	endtask

	initial begin
		err_count = 0;
		tests_run = 0;
		base = 0;
		SYS_RST = 1'b1;
		ISSUE = 1'b0;
		ISSUE_CMD = '0;
		SLOW = 1'b0;
		repeat (6) @(posedge MCLK);
		SYS_RST <= 1'b0;
		t_timing();
		t_single();
		t_double();
		t_stream();
		t_refuse();
		report_and_stop();
	end
endmodule
